//--- include/sss_pkg.sv
// Purpose: constants for the servo slot task scheduler
// Assumes: 100 MHz system clock, one reset
// Notes: task 0 is the system task; tasks 4 and 5 form the high class
//
// Overview of operation
// - a servo tick marks every 1 ms period; all timing follows it.
// - the i/o refresh runs at period start, before any slot.
// - programs see the input snapshot latched in the previous period.
// - refresh order: transfer snapshot, analogue refs, digital outputs, new snapshot.
// - digital output pins follow the output variable at each refresh.
// - each period splits into three slots granted to tasks; the refresh shortens the first.
// - six task numbers; tasks 1 to 5 each run one program.
// - task 0 is the system task, never given to a user program.
// - tasks 5 and 4 are high priority; 3, 2, 1 are low.
// - task 0 joins the low priority rotation.
// - a run without task number takes the highest free task.
// - mixed classes: two slots go high, one slot goes low.
// - a single class spreads its tasks over all three slots.
// - round-robin grant continues across periods for equal shares.
// - a lone high task takes both high slots each period.
// - a program whose last compile failed is refused to start.
// - halt-all stops every running task except task 0 at once.
// - an error without handler halts the task, task 0 excepted, and flags host status.
// - a motion error drops drive enable when selected in the axis mask.
// - host status shows the faulted axis and the error type.
// - a failed host transfer sets bit 07 of host status word n+7.
package sss_pkg;
   localparam int SSS_CLK_MHZ = 100;
   localparam int SSS_SERVO_US = 1000;
   localparam int SSS_SERVO_CYC = SSS_CLK_MHZ * SSS_SERVO_US;
   localparam int SSS_SLOTS = 3;
   localparam int SSS_SLOT_CYC = SSS_SERVO_CYC / SSS_SLOTS;
   localparam int SSS_TASKS = 6;
   localparam int SSS_AXES = 4;
   localparam int SSS_ERR_W = 4;
   localparam int SSS_IN_W = 16;
   localparam int SSS_OUT_W = 8;
   localparam int SSS_DAC_W = 16;
   localparam int SSS_HIF_ERR_BIT = 7;
   localparam logic [5:0] SSS_HIGH_MASK = 6'h30;
   localparam logic [5:0] SSS_LOW_MASK = 6'h0F;
   localparam logic [2:0] SSS_NO_TASK = 3'h7;
   typedef enum logic [2:0] {
      SSS_R_IDLE = 3'b000,
      SSS_R_XFER = 3'b001,
      SSS_R_DAC = 3'b010,
      SSS_R_DOUT = 3'b011,
      SSS_R_LATCH = 3'b100
   } sss_refresh_e;
endpackage

//--- rtl/sss_rr_pick.sv
// Purpose: round-robin pick of the next task in a candidate set
// Assumes: six tasks, pointer holds the last granted task
// Notes: purely combinational
`timescale 1ns/10ps
module sss_rr_pick
   import sss_pkg::*;
(
   input wire logic [5:0] i_cand,
   input wire logic [2:0] i_last,
   output logic o_found,
   output logic [2:0] o_pick
);
   // search upward from the task after the last grant, wrapping round
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      o_found = 1'b0;
      o_pick = 3'h0;
      for (int k = 1; k <= SSS_TASKS; k++) begin
         idx = 3'((int'(i_last) + k) % SSS_TASKS);
         if (!o_found && i_cand[idx]) begin
            o_found = 1'b1;
            o_pick = idx;
         end
      end
   end
endmodule

//--- rtl/sss_scheduler.sv
// Purpose: servo tick, i/o refresh sequence and slot task scheduler
// Assumes: all inputs synchronous to i_sys_clk; status bits are plain ports
// Notes: program execution itself lives elsewhere; this block grants slots
`timescale 1ns/10ps
module sss_scheduler
   import sss_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [SSS_IN_W-1:0] i_input_pins,
   input wire logic [SSS_OUT_W-1:0] i_output_port_word,
   input wire logic i_output_port_we,
   input wire logic [SSS_AXES*SSS_DAC_W-1:0] i_speed_ref,
   input wire logic i_run_req,
   input wire logic i_run_task_given,
   input wire logic [2:0] i_run_task,
   input wire logic i_compile_ok,
   input wire logic i_stop_req,
   input wire logic [2:0] i_stop_task,
   input wire logic i_halt_all,
   input wire logic i_prog_error,
   input wire logic [2:0] i_prog_error_task,
   input wire logic i_error_handler,
   input wire logic [SSS_AXES-1:0] i_motion_error,
   input wire logic [SSS_ERR_W-1:0] i_motion_error_type,
   input wire logic [SSS_AXES*SSS_ERR_W-1:0] i_axis_fault_disable_select,
   input wire logic [SSS_AXES-1:0] i_drive_enable_req,
   input wire logic i_host_read_transfer_fail,
   input wire logic i_host_write_transfer_fail,
   input wire logic i_host_err_clear,
   output logic o_servo_tick,
   output logic o_slot_start,
   output logic [1:0] o_slot_idx,
   output logic o_slot_valid,
   output logic [2:0] o_slot_task,
   output logic [5:0] o_task_active,
   output logic o_run_accept,
   output logic o_run_refused,
   output logic [2:0] o_run_task,
   output logic [SSS_IN_W-1:0] o_input_word,
   output logic [SSS_OUT_W-1:0] o_output_pins,
   output logic [SSS_AXES*SSS_DAC_W-1:0] o_dac_out,
   output logic [SSS_AXES-1:0] o_drive_enable,
   output logic o_prog_error_flag,
   output logic [2:0] o_prog_error_task,
   output logic o_motion_error_flag,
   output logic [1:0] o_motion_error_axis,
   output logic [SSS_ERR_W-1:0] o_motion_error_type,
   output logic [15:0] o_host_status_n7
);
   logic [16:0] period_cnt_r;
   logic [15:0] slot_cnt_r;
   logic [1:0] slot_idx_r;
   logic tick;
   logic slot_end;
   sss_refresh_e ref_state_r;
   logic [SSS_IN_W-1:0] snapshot_r;
   logic [SSS_OUT_W-1:0] output_port_word_r;
   logic [5:0] active_r;
   logic [2:0] last_hi_r;
   logic [2:0] last_lo_r;
   logic [2:0] slot_task_r;
   logic slot_valid_r;
   logic slot_start_r;
   logic [1:0] hi_used_r;
   logic [5:0] hi_cand;
   logic [5:0] lo_cand;
   logic [5:0] all_cand;
   logic mixed;
   logic hi_found;
   logic lo_found;
   logic all_found;
   logic [2:0] hi_pick;
   logic [2:0] lo_pick;
   logic [2:0] all_pick;
   logic [2:0] free_pick;
   logic free_found;
   logic hif_err_r;

   // period counter yields one tick per 1 ms
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         period_cnt_r <= 17'h00000;
      end else if (period_cnt_r == 17'(SSS_SERVO_CYC - 1)) begin
         period_cnt_r <= 17'h00000;
      end else begin
         period_cnt_r <= period_cnt_r + 17'h00001;
      end
   end
   assign tick = (period_cnt_r == 17'(SSS_SERVO_CYC - 1));
   assign o_servo_tick = tick;

   // refresh walks its four steps right after the tick
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ref_state_r <= SSS_R_IDLE;
      end else begin
         case (ref_state_r)
            SSS_R_IDLE: ref_state_r <= tick ? SSS_R_XFER : SSS_R_IDLE;
            SSS_R_XFER: ref_state_r <= SSS_R_DAC;
            SSS_R_DAC: ref_state_r <= SSS_R_DOUT;
            SSS_R_DOUT: ref_state_r <= SSS_R_LATCH;
            SSS_R_LATCH: ref_state_r <= SSS_R_IDLE;
            default: ref_state_r <= SSS_R_IDLE;
         endcase
      end
   end

   // slots start only after the refresh, so the first slot is shortened by it
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         // park on the last slot so nothing is granted before the first tick
         slot_cnt_r <= 16'(SSS_SLOT_CYC - 1);
         slot_idx_r <= 2'(SSS_SLOTS - 1);
      end else if (tick) begin
         slot_cnt_r <= 16'h0000;
         slot_idx_r <= 2'h0;
      end else if (slot_end && slot_idx_r != 2'(SSS_SLOTS - 1)) begin
         slot_cnt_r <= 16'h0000;
         slot_idx_r <= slot_idx_r + 2'h1;
      end else if (!slot_end) begin
         slot_cnt_r <= slot_cnt_r + 16'h0001;
      end
   end
   assign slot_end = (slot_cnt_r == 16'(SSS_SLOT_CYC - 1));

   // input snapshot and program-visible input word
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         snapshot_r <= '0;
         o_input_word <= '0;
      end else begin
         if (ref_state_r == SSS_R_XFER) begin
            o_input_word <= snapshot_r;
         end
         if (ref_state_r == SSS_R_LATCH) begin
            snapshot_r <= i_input_pins;
         end
      end
   end

   // analogue speed references only move at refresh
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dac_out <= '0;
      end else if (ref_state_r == SSS_R_DAC) begin
         o_dac_out <= i_speed_ref;
      end
   end

   // output variable; pins copy it once per period
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         output_port_word_r <= '0;
         o_output_pins <= '0;
      end else begin
         if (i_output_port_we) begin
            output_port_word_r <= i_output_port_word;
         end
         if (ref_state_r == SSS_R_DOUT) begin
            o_output_pins <= output_port_word_r;
         end
      end
   end

   // candidate sets per class; task 0 sits with the low class
   assign hi_cand = active_r & SSS_HIGH_MASK;
   assign lo_cand = active_r & SSS_LOW_MASK;
   assign all_cand = active_r;
   assign mixed = (|hi_cand) && (|lo_cand);

   sss_rr_pick u_hi_pick (
      .i_cand(hi_cand),
      .i_last(last_hi_r),
      .o_found(hi_found),
      .o_pick(hi_pick)
   );
   sss_rr_pick u_lo_pick (
      .i_cand(lo_cand),
      .i_last(last_lo_r),
      .o_found(lo_found),
      .o_pick(lo_pick)
   );
   sss_rr_pick u_all_pick (
      .i_cand(all_cand),
      .i_last(hi_found ? last_hi_r : last_lo_r),
      .o_found(all_found),
      .o_pick(all_pick)
   );

   // slot grant at the start of each slot
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         slot_task_r <= SSS_NO_TASK;
         slot_valid_r <= 1'b0;
         slot_start_r <= 1'b0;
         last_hi_r <= 3'h3;
         last_lo_r <= 3'h5;
         hi_used_r <= 2'h0;
      end else begin
         slot_start_r <= 1'b0;
         if (ref_state_r == SSS_R_LATCH || (slot_end && slot_idx_r != 2'(SSS_SLOTS - 1))) begin
            slot_start_r <= 1'b1;
            if (ref_state_r == SSS_R_LATCH) begin
               hi_used_r <= 2'h0;
            end
            if (mixed && (ref_state_r == SSS_R_LATCH || hi_used_r == 2'h1)) begin
               slot_task_r <= hi_pick;
               slot_valid_r <= 1'b1;
               last_hi_r <= hi_pick;
               hi_used_r <= (ref_state_r == SSS_R_LATCH) ? 2'h1 : 2'h2;
            end else if (mixed) begin
               slot_task_r <= lo_pick;
               slot_valid_r <= 1'b1;
               last_lo_r <= lo_pick;
            end else if (all_found) begin
               slot_task_r <= all_pick;
               slot_valid_r <= 1'b1;
               if (hi_found) begin
                  last_hi_r <= all_pick;
               end else begin
                  last_lo_r <= all_pick;
               end
            end else begin
               slot_task_r <= SSS_NO_TASK;
               slot_valid_r <= 1'b0;
            end
         end
      end
   end
   assign o_slot_task = slot_task_r;
   assign o_slot_valid = slot_valid_r;
   assign o_slot_start = slot_start_r;
   assign o_slot_idx = slot_idx_r;

   // highest free user task, never task 0
   always_comb begin
      free_found = 1'b0;
      free_pick = 3'h0;
      for (int t = 1; t < SSS_TASKS; t++) begin
         if (!active_r[t]) begin
            free_found = 1'b1;
            free_pick = 3'(t);
         end
      end
   end

   // task activity: run, stop, halt-all and unhandled errors
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         active_r <= 6'h01;
         o_run_accept <= 1'b0;
         o_run_refused <= 1'b0;
         o_run_task <= 3'h0;
      end else begin
         o_run_accept <= 1'b0;
         o_run_refused <= 1'b0;
         if (i_halt_all) begin
            active_r <= 6'h01;
         end else begin
            if (i_stop_req && i_stop_task != 3'h0 && i_stop_task < 3'(SSS_TASKS)) begin
               active_r[i_stop_task] <= 1'b0;
            end
            if (i_prog_error && !i_error_handler && i_prog_error_task != 3'h0
                && i_prog_error_task < 3'(SSS_TASKS)) begin
               active_r[i_prog_error_task] <= 1'b0;
            end
            if (i_run_req) begin
               if (!i_compile_ok) begin
                  o_run_refused <= 1'b1;
               end else if (i_run_task_given) begin
                  if (i_run_task == 3'h0 || i_run_task >= 3'(SSS_TASKS) || active_r[i_run_task]) begin
                     o_run_refused <= 1'b1;
                  end else begin
                     active_r[i_run_task] <= 1'b1;
                     o_run_accept <= 1'b1;
                     o_run_task <= i_run_task;
                  end
               end else if (free_found) begin
                  active_r[free_pick] <= 1'b1;
                  o_run_accept <= 1'b1;
                  o_run_task <= free_pick;
               end else begin
                  o_run_refused <= 1'b1;
               end
            end
         end
      end
   end
   assign o_task_active = active_r;

   // program error report, held until the next error
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prog_error_flag <= 1'b0;
         o_prog_error_task <= 3'h0;
      end else if (i_prog_error && !i_error_handler) begin
         o_prog_error_flag <= 1'b1;
         o_prog_error_task <= i_prog_error_task;
      end
   end

   // per-axis drive enable gated by the fault-disable selection
   for (genvar a = 0; a < SSS_AXES; a++) begin : g_axis
      logic tripped_r;
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
         if (i_rst) begin
            tripped_r <= 1'b0;
         end else if (i_motion_error[a]
                      && |(i_motion_error_type & i_axis_fault_disable_select[a*SSS_ERR_W +: SSS_ERR_W])) begin
            tripped_r <= 1'b1;
         end else if (!i_drive_enable_req[a]) begin
            tripped_r <= 1'b0; // re-arm once software drops the enable
         end
      end
      assign o_drive_enable[a] = i_drive_enable_req[a] && !tripped_r;
   end

   // motion error axis and type; lowest axis wins on a tie
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_motion_error_flag <= 1'b0;
         o_motion_error_axis <= 2'h0;
         o_motion_error_type <= '0;
      end else if (|i_motion_error) begin
         o_motion_error_flag <= 1'b1;
         o_motion_error_type <= i_motion_error_type;
         for (int a = SSS_AXES - 1; a >= 0; a--) begin
            if (i_motion_error[a]) begin
               o_motion_error_axis <= 2'(a);
            end
         end
      end
   end

   // host interface error flag; a new failure wins over the clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         hif_err_r <= 1'b0;
      end else if (i_host_read_transfer_fail || i_host_write_transfer_fail) begin
         hif_err_r <= 1'b1;
      end else if (i_host_err_clear) begin
         hif_err_r <= 1'b0;
      end
   end
   assign o_host_status_n7 = 16'(hif_err_r) << SSS_HIF_ERR_BIT;

   // refresh order: input transfer one edge after the tick, latch three later
   refresh_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      tick |=> ref_state_r == SSS_R_XFER ##3 ref_state_r == SSS_R_LATCH)
      else $error("refresh steps out of order");
   // snapshot taken last period is what programs see
   input_snapshot_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ref_state_r == SSS_R_XFER |=> o_input_word == $past(snapshot_r))
      else $error("input word not loaded from previous snapshot");
   // pins follow output word at refresh
   output_pins_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ref_state_r == SSS_R_DOUT |=> o_output_pins == $past(output_port_word_r))
      else $error("output pins not refreshed");
   // first slot only after the refresh finishes
   slot_after_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      tick |-> !slot_start_r ##1 !slot_start_r [*4] ##1 slot_start_r)
      else $error("slot began before refresh");
   // task 0 never granted to user programs
   task_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_run_accept |-> o_run_task != 3'h0)
      else $error("user program placed on system task");
   // failed compile never starts; halt-all drops the request without a refusal
   compile_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_run_req && !i_compile_ok && !i_halt_all |=> o_run_refused && !o_run_accept)
      else $error("program ran after failed compile");
   // halt all leaves only the system task
   halt_all_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_halt_all |=> active_r == 6'h01)
      else $error("task survived halt all");
   // mixed classes: first slot goes high
   mixed_high_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ref_state_r == SSS_R_LATCH && mixed |=> SSS_HIGH_MASK[slot_task_r])
      else $error("high slot not granted to high task");
   // host error flag reaches bit 07
   host_error_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_host_read_transfer_fail || i_host_write_transfer_fail |=> o_host_status_n7[7])
      else $error("host error flag not set");
endmodule

//--- testbench/sss_host_model.sv
// Purpose: host controller stand-in that injects and services transfer faults
// Assumes: host status word sampled on the system clock
// Notes: clear follows a fixed poll delay, as a slow host program would
`timescale 1ns/10ps
module sss_host_model #(
   parameter int POLL_WAIT = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [1:0] i_inject,
   input wire logic [15:0] i_status,
   output logic o_read_fail,
   output logic o_write_fail,
   output logic o_err_clear,
   output logic [7:0] o_handled
);
   int wait_r;
   // one-cycle fault pulses when the bench asks for them
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_read_fail <= 1'b0;
         o_write_fail <= 1'b0;
      end else begin
         o_read_fail <= i_inject[0];
         o_write_fail <= i_inject[1];
      end
   end
   // poll the flag, clear it late; guard avoids a double clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wait_r <= 0;
         o_err_clear <= 1'b0;
         o_handled <= 8'h00;
      end else begin
         o_err_clear <= 1'b0;
         if (i_status[7] && !o_err_clear) begin
            if (wait_r == POLL_WAIT) begin
               o_err_clear <= 1'b1;
               o_handled <= o_handled + 8'h01;
               wait_r <= 0;
            end else begin
               wait_r <= wait_r + 1;
            end
         end else begin
            wait_r <= 0;
         end
      end
   end
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench for the slot scheduler
// Assumes: fixed 1 ms period, so each servo period costs 100000 cycles
// Notes: three periods walk the grant rotation; faults are checked afterwards
`timescale 1ns/10ps
module tb;
   import sss_pkg::*;
   typedef struct packed {logic given; logic [2:0] task_n; logic ok; logic acc; logic [2:0] exp_t;} sss_run_s;
   logic i_sys_clk, i_rst, i_output_port_we, i_run_req, i_run_task_given, i_compile_ok, i_stop_req, i_halt_all;
   logic i_prog_error, i_error_handler, i_host_read_transfer_fail, i_host_write_transfer_fail, i_host_err_clear;
   logic [2:0] i_run_task, i_stop_task, i_prog_error_task;
   logic [15:0] i_input_pins, i_axis_fault_disable_select, snap;
   logic [7:0] i_output_port_word, handled;
   logic [63:0] i_speed_ref;
   logic [3:0] i_motion_error, i_motion_error_type, i_drive_enable_req;
   logic [1:0] inject;
   logic o_servo_tick, o_slot_start, o_slot_valid, o_run_accept, o_run_refused, o_prog_error_flag;
   logic o_motion_error_flag;
   logic [1:0] o_slot_idx, o_motion_error_axis;
   logic [2:0] o_slot_task, o_run_task, o_prog_error_task;
   logic [5:0] o_task_active;
   logic [15:0] o_input_word, o_host_status_n7;
   logic [7:0] o_output_pins;
   logic [63:0] o_dac_out;
   logic [3:0] o_drive_enable, o_motion_error_type;
   int fails, n_checks, cyc, last_tick;
   sss_run_s rows [7] = '{'{1'b1, 3'h0, 1'b1, 1'b0, 3'h0}, '{1'b1, 3'h6, 1'b1, 1'b0, 3'h0},
      '{1'b1, 3'h1, 1'b0, 1'b0, 3'h0}, '{1'b1, 3'h1, 1'b1, 1'b1, 3'h1}, '{1'b1, 3'h1, 1'b1, 1'b0, 3'h0},
      '{1'b0, 3'h0, 1'b1, 1'b1, 3'h5}, '{1'b0, 3'h0, 1'b1, 1'b1, 3'h4}};

   sss_scheduler u_dut (.*);
   sss_host_model u_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inject(inject), .i_status(o_host_status_n7),
      .o_read_fail(i_host_read_transfer_fail), .o_write_fail(i_host_write_transfer_fail),
      .o_err_clear(i_host_err_clear), .o_handled(handled));

   // 100 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ceiling: three periods plus the fault tests
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 380000) begin
         fails++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // inputs move 1 ns after the edge so the design never races them
   task automatic step();
      @(posedge i_sys_clk);
      #1;
   endtask

   task automatic run(input sss_run_s r);
      i_run_req = 1'b1;
      i_run_task_given = r.given;
      i_run_task = r.task_n;
      i_compile_ok = r.ok;
      step();
      i_run_req = 1'b0;
      chk("accept", o_run_accept, r.acc);
      chk("refused", o_run_refused, !r.acc);
      if (r.acc) chk("run task", o_run_task, r.exp_t);
      step();
   endtask

   task automatic stop(input logic [2:0] t);
      i_stop_req = 1'b1;
      i_stop_task = t;
      step();
      i_stop_req = 1'b0;
      step();
   endtask

   // new output word and speed refs for the next refresh
   task automatic setio(input logic [7:0] w);
      i_output_port_word = w;
      i_speed_ref = {8{w}};
      i_output_port_we = 1'b1;
      step();
      i_output_port_we = 1'b0;
   endtask

   // one servo period: tick spacing, refresh order, then the three grants
   task automatic period(input logic [2:0] t0, input logic [2:0] t1, input logic [2:0] t2);
      int kin, kdac, kpin, kslot, gap;
      logic [15:0] old_snap;
      logic [2:0] exp_t [3];
      exp_t = '{t0, t1, t2};
      gap = 0;
      while (o_servo_tick !== 1'b1 && gap < 100010) begin
         step();
         gap++;
      end
      if (last_tick == 0) chk("idle before tick", o_slot_valid, 1'b0);
      if (last_tick > 0) chk("tick spacing", cyc - last_tick, 100000);
      last_tick = cyc;
      old_snap = snap;
      i_input_pins = ~i_input_pins;
      snap = i_input_pins;
      kin = 0;
      kdac = 0;
      kpin = 0;
      kslot = 0;
      for (int j = 1; j <= 8; j++) begin
         step();
         if (kin == 0 && o_input_word === old_snap) kin = j;
         if (kdac == 0 && o_dac_out === i_speed_ref) kdac = j;
         if (kpin == 0 && o_output_pins === i_output_port_word) kpin = j;
         if (kslot == 0 && o_slot_start === 1'b1) begin
            kslot = j;
            chk("slot 0 idx", o_slot_idx, 2'h0);
            chk("slot 0 task", o_slot_task, exp_t[0]);
         end
      end
      chk("input word", o_input_word, old_snap);
      chk("dac", o_dac_out, i_speed_ref);
      chk("pins", o_output_pins, i_output_port_word);
      chk("refresh order", kin > 0 && kin < kdac && kdac < kpin && kpin < kslot, 1'b1);
      for (int s = 1; s < 3; s++) begin
         gap = 0;
         do begin
            step();
            gap++;
         end while (o_slot_start !== 1'b1 && gap < 34000);
         // slot 1 is counted from eight cycles past the tick and starts SSS_SLOT_CYC + 1 cycles after the tick
         chk("slot gap", gap, (s == 1) ? SSS_SLOT_CYC - 7 : SSS_SLOT_CYC);
         chk("slot idx", o_slot_idx, s[1:0]);
         chk("slot valid", o_slot_valid, 1'b1);
         chk("slot task", o_slot_task, exp_t[s]);
      end
      $display("period done at cycle %0d", cyc);
   endtask

   // main sequence
   initial begin
      {i_output_port_we, i_run_req, i_run_task_given, i_stop_req, i_halt_all, i_prog_error} = '0;
      {i_run_task, i_stop_task, i_prog_error_task, i_output_port_word, i_speed_ref, inject} = '0;
      {i_motion_error, i_motion_error_type, i_axis_fault_disable_select, i_error_handler} = '0;
      i_compile_ok = 1'b1;
      i_drive_enable_req = 4'hF;
      i_input_pins = 16'hA5C3;
      snap = 16'h0000;
      i_rst = 1'b1;
      repeat (2) step();
      i_rst = 1'b0;
      chk("active", o_task_active, 6'h01);
      chk("slot task", o_slot_task, 3'h7);
      chk("pins", o_output_pins, 8'h00);
      chk("status", o_host_status_n7, 16'h0000);
      $display("reset test done");
      foreach (rows[i]) run(rows[i]);
      stop(3'h5);
      chk("active", o_task_active, 6'h13);
      $display("run table done");
      setio(8'h3C);
      period(3'h4, 3'h4, 3'h0);
      run('{1'b1, 3'h5, 1'b1, 1'b1, 3'h5});
      run('{1'b1, 3'h2, 1'b1, 1'b1, 3'h2});
      setio(8'hC3);
      period(3'h5, 3'h4, 3'h1);
      stop(3'h4);
      stop(3'h5);
      setio(8'h5A);
      period(3'h2, 3'h0, 3'h1);
      // error with and without a handler
      i_error_handler = 1'b1;
      i_prog_error_task = 3'h2;
      for (int h = 0; h < 2; h++) begin
         i_prog_error = 1'b1;
         step();
         i_prog_error = 1'b0;
         step();
         chk("active", o_task_active, h ? 6'h03 : 6'h07);
         chk("error flag", o_prog_error_flag, h[0]);
         i_error_handler = 1'b0;
      end
      chk("error task", o_prog_error_task, 3'h2);
      run('{1'b1, 3'h5, 1'b1, 1'b1, 3'h5});
      // halt together with a run request
      {i_halt_all, i_run_req, i_run_task_given, i_run_task} = {3'b111, 3'h4};
      step();
      {i_halt_all, i_run_req} = 2'b00;
      step();
      chk("active", o_task_active, 6'h01);
      $display("task error tests done");
      // axis 1 masked for type 4, axis 2 not
      i_axis_fault_disable_select = 16'h0040;
      i_motion_error_type = 4'h4;
      for (int a = 1; a < 3; a++) begin
         i_motion_error = 4'h1 << a;
         step();
         i_motion_error = 4'h0;
         step();
         chk("drive enable", o_drive_enable, 4'hD);
         chk("motion axis", o_motion_error_axis, a[1:0]);
         chk("motion type", o_motion_error_type, 4'h4);
      end
      chk("motion flag", o_motion_error_flag, 1'b1);
      i_drive_enable_req = 4'hD;
      step();
      i_drive_enable_req = 4'hF;
      step();
      chk("drive enable", o_drive_enable, 4'hF);
      $display("motion tests done");
      // read then write failure, each serviced by the host model
      for (int f = 0; f < 2; f++) begin
         inject = 2'b01 << f;
         step();
         inject = 2'b00;
         step();
         chk("host flag", o_host_status_n7, 16'h0080);
         repeat (8) step();
         chk("host flag", o_host_status_n7, 16'h0000);
         chk("handled", handled, f + 1);
      end
      $display("host error tests done");
      close_out();
   end
endmodule
